//--- bench/alu_skip_table_assertions.sv
`include "alu_skip_table_defines.vh"
`default_nettype none
module alu_skip_table_assertions #(
  parameter PROG_ADDR_WIDTH = 16,
  parameter PROG_WORD_WIDTH = 16
) (
  // clock, reset, issue, data memory and program read
  input wire logic clk, reset, opValid, opReady,
  input wire logic [4:0] opCode,
  input wire logic [2:0] bitSelect,
  input wire logic [7:0] memReadData, memWriteData,
  input wire logic memWrite, progRead,
  // program memory
  input wire logic [PROG_ADDR_WIDTH-1:0] progAddr,
  input wire logic [PROG_WORD_WIDTH-1:0] progData,
  // state
  input wire logic [7:0] workingRegister, tablePointerLow, tableLatchHigh,
  input wire logic zeroFlag, carryFlag, skipTaken, dummyCycle
);
  logic bitSeen;
  wire logic go = opValid && opReady;
  always @(posedge clk) bitSeen <= memReadData[bitSelect];
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  property p_skipCopy;
    go && opCode == `OP_SKIP_ZERO_COPY |=>
      skipTaken == (workingRegister == 8'h00) && $stable(zeroFlag);
  endproperty
  a_skipCopy: assert property (p_skipCopy)
    else $error("zero copy skip wrong");
  property p_skipBit;
    go && opCode == `OP_SKIP_BIT_ZERO |=> skipTaken == !bitSeen;
  endproperty
  a_skipBit: assert property (p_skipBit)
    else $error("bit skip wrong");
  property p_skipSlot;
    skipTaken |-> dummyCycle && !opReady ##1 !dummyCycle && opReady;
  endproperty
  a_skipSlot: assert property (p_skipSlot)
    else $error("skip slot length wrong");
  property p_dummyQuiet;
    dummyCycle |-> !memWrite && !progRead ##1
      $stable(workingRegister) && $stable(zeroFlag) && $stable(carryFlag);
  endproperty
  a_dummyQuiet: assert property (p_dummyQuiet)
    else $error("dummy cycle changed state");
  property p_incFirst;
    go && opCode == `OP_TABLE_READ_INC |=> progRead &&
      tablePointerLow == $past(tablePointerLow) + 8'h01 &&
      progAddr[7:0] == tablePointerLow;
  endproperty
  a_incFirst: assert property (p_incFirst)
    else $error("pointer not bumped first");
  property p_lastPage;
    go && opCode == `OP_TABLE_READ_LAST_PAGE |=> progRead &&
      &progAddr[PROG_ADDR_WIDTH-1:8] && progAddr[7:0] == tablePointerLow;
  endproperty
  a_lastPage: assert property (p_lastPage)
    else $error("last page address wrong");
  property p_tableWrite;
    progRead |=> memWrite && memWriteData == progData[7:0] &&
      tableLatchHigh == progData[15:8];
  endproperty
  a_tableWrite: assert property (p_tableWrite)
    else $error("table word split wrong");
  property p_clear;
    go && opCode == `OP_WIDE_CLEAR |=> memWrite &&
      memWriteData == 8'h00 && $stable(zeroFlag) && $stable(carryFlag);
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear wrong");
  c_skip: cover property (skipTaken);
  c_table: cover property (progRead ##1 memWrite);
  c_clear: cover property (go && opCode == `OP_WIDE_CLEAR);
endmodule
bind mcu_alu_skip_table alu_skip_table_assertions #(
  .PROG_ADDR_WIDTH(PROG_ADDR_WIDTH), .PROG_WORD_WIDTH(PROG_WORD_WIDTH)
) i_alu_skip_table_assertions (
  .clk(clk), .reset(reset), .opValid(opValid), .opReady(opReady),
  .opCode(opCode), .bitSelect(bitSelect), .memReadData(memReadData),
  .memWriteData(memWriteData), .memWrite(memWrite), .progRead(progRead),
  .progAddr(progAddr), .progData(progData),
  .workingRegister(workingRegister), .tablePointerLow(tablePointerLow),
  .tableLatchHigh(tableLatchHigh), .zeroFlag(zeroFlag),
  .carryFlag(carryFlag), .skipTaken(skipTaken), .dummyCycle(dummyCycle)
);
`default_nettype wire

//--- bench/mcu_alu_skip_table_tb.sv
`include "alu_skip_table_defines.vh"
`default_nettype none
module mcu_alu_skip_table_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic reset, opValid, opReady, memWrite, progRead, skipTaken;
  logic dummyCycle, zeroFlag, carryFlag, nibbleCarryFlag, signedExcessFlag;
  logic signedCarryFlag, tablePointerLowLoad, tablePointerHighLoad;
  logic [4:0] opCode;
  logic [2:0] bitSelect;
  logic [7:0] immediate, memReadData, memWriteData, tablePointerLoadData;
  logic [7:0] workingRegister, tablePointerLow, tablePointerHigh;
  logic [7:0] tableLatchHigh;
  logic [11:0] dataAddr, memAddr, memWriteAddr;
  logic [15:0] progAddr, progData;
  int n_fail, comparisons;
  // program word: high byte = address low, low byte = address high
  assign progData = {progAddr[7:0], progAddr[15:8]};
  mcu_alu_skip_table i_mcu_alu_skip_table (
    .clk(clk), .reset(reset), .opValid(opValid), .opCode(opCode),
    .bitSelect(bitSelect), .immediate(immediate), .dataAddr(dataAddr),
    .opReady(opReady), .memAddr(memAddr), .memReadData(memReadData),
    .memWrite(memWrite), .memWriteAddr(memWriteAddr),
    .memWriteData(memWriteData), .progRead(progRead), .progAddr(progAddr),
    .progData(progData), .tablePointerLowLoad(tablePointerLowLoad),
    .tablePointerHighLoad(tablePointerHighLoad),
    .tablePointerLoadData(tablePointerLoadData),
    .workingRegister(workingRegister), .tablePointerLow(tablePointerLow),
    .tablePointerHigh(tablePointerHigh), .tableLatchHigh(tableLatchHigh),
    .zeroFlag(zeroFlag), .carryFlag(carryFlag),
    .nibbleCarryFlag(nibbleCarryFlag), .signedExcessFlag(signedExcessFlag),
    .signedCarryFlag(signedCarryFlag), .skipTaken(skipTaken),
    .dummyCycle(dummyCycle));
  task automatic print_verdict;
    $display("mismatches %0d comparisons %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic issue(input logic [4:0] c, input logic [7:0] m);
    @(negedge clk);
    opValid = 1'b1;
    opCode = c;
    memReadData = m;
    @(negedge clk);
    opValid = 1'b0;
  endtask
  task automatic alu(input logic [4:0] c, input logic [7:0] m, r,
      input logic toMem, z);
    issue(c, m);
    chk(toMem ? memWriteData : workingRegister, r);
    chk({6'h00, memWrite, zeroFlag}, {6'h00, toMem, z});
  endtask
  task automatic flags(input logic [7:0] e);
    chk({3'h0, signedExcessFlag, nibbleCarryFlag, carryFlag,
      signedCarryFlag, zeroFlag}, e);
  endtask
  task automatic tbl(input logic [4:0] c, input logic [7:0] hi, lo);
    issue(c, 8'h00);
    chk(progAddr[15:8], hi);
    chk(tablePointerLow, lo);
    chk(progAddr[7:0], lo);
    @(negedge clk);
    chk({7'h00, memWrite}, 8'h01);
    chk(memWriteData, hi);
    chk(tableLatchHigh, lo);
  endtask
  task automatic t_skip;
    issue(`OP_SKIP_ZERO_COPY, 8'h00);
    chk(workingRegister, 8'h00);
    chk({skipTaken, dummyCycle, opReady}, 8'h06);
    issue(`OP_SKIP_ZERO_COPY, 8'h5a);
    chk({workingRegister[6:0], skipTaken}, 8'hb4);
    issue(`OP_SKIP_BIT_ZERO, 8'hf7);
    chk({7'h00, skipTaken}, 8'h01);
    issue(`OP_SKIP_BIT_ZERO, 8'h08);
    chk({7'h00, skipTaken}, 8'h00);
  endtask
  task automatic t_table;
    @(negedge clk);
    tablePointerLowLoad = 1'b1;
    tablePointerLoadData = 8'h34;
    @(negedge clk);
    tablePointerLowLoad = 1'b0;
    tablePointerHighLoad = 1'b1;
    tablePointerLoadData = 8'h12;
    @(negedge clk);
    tablePointerHighLoad = 1'b0;
    tbl(`OP_TABLE_READ_PAGED, 8'h12, 8'h34);
    chk(memWriteAddr[11:4], 8'hf3);
    dataAddr = 12'h05c;
    tbl(`OP_TABLE_READ_LAST_PAGE, 8'hff, 8'h34);
    chk(memWriteAddr[11:4], 8'h05);
    chk(memAddr[11:4], 8'h05);
    tbl(`OP_TABLE_READ_INC, 8'h12, 8'h35);
    tbl(`OP_TABLE_READ_INC_LAST_PAGE, 8'hff, 8'h36);
  endtask
  task automatic t_arith;
    alu(`OP_WIDE_MOVE_TO_WORK, 8'h7f, 8'h7f, 0, 0);
    alu(`OP_WIDE_ADD, 8'h01, 8'h80, 0, 0);
    flags(8'h18);
    alu(`OP_WIDE_ADD_CARRY_MEMORY, 8'h80, 8'h00, 1, 1);
    flags(8'h17);
    alu(`OP_WIDE_ADD_CARRY, 8'h01, 8'h82, 0, 0);
    flags(8'h02);
    alu(`OP_WIDE_MOVE_TO_WORK, 8'h8b, 8'h8b, 0, 0);
    alu(`OP_WIDE_DECIMAL_ADJUST, 8'h00, 8'h91, 1, 0);
    alu(`OP_WIDE_MOVE_TO_WORK, 8'ha0, 8'ha0, 0, 0);
    alu(`OP_WIDE_DECIMAL_ADJUST, 8'h00, 8'h00, 1, 0);
    chk({7'h00, carryFlag}, 8'h01);
  endtask
  task automatic t_logic;
    alu(`OP_XOR_TO_MEMORY, 8'ha0, 8'h00, 1, 1);
    alu(`OP_XOR_IMMEDIATE, 8'h00, 8'haf, 0, 0);
    alu(`OP_WIDE_AND_MEMORY, 8'h50, 8'h00, 1, 1);
    alu(`OP_WIDE_AND, 8'h3c, 8'h2c, 0, 0);
    alu(`OP_WIDE_OR_MEMORY, 8'h00, 8'h2c, 1, 0);
    alu(`OP_WIDE_OR, 8'hc0, 8'hec, 0, 0);
    alu(`OP_XOR, 8'hec, 8'h00, 0, 1);
    alu(`OP_WIDE_COMPLEMENT, 8'hff, 8'h00, 1, 1);
    alu(`OP_WIDE_COMPLEMENT_TO_WORK, 8'h5a, 8'ha5, 0, 0);
    alu(`OP_WIDE_DECREMENT, 8'h01, 8'h00, 1, 1);
    alu(`OP_WIDE_DECREMENT_TO_WORK, 8'h00, 8'hff, 0, 0);
    alu(`OP_WIDE_INCREMENT, 8'hff, 8'h00, 1, 1);
    alu(`OP_WIDE_INCREMENT_TO_WORK, 8'h7f, 8'h80, 0, 0);
    alu(`OP_WIDE_ROTATE_LEFT, 8'h81, 8'h03, 1, 0);
    alu(`OP_WIDE_MOVE_TO_MEMORY, 8'h00, 8'h80, 1, 0);
    alu(`OP_WIDE_CLEAR_BIT, 8'hff, 8'hdf, 1, 0);
    alu(`OP_WIDE_CLEAR, 8'h77, 8'h00, 1, 0);
    chk({7'h00, carryFlag}, 8'h01);
  endtask
  initial begin
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (2000) @(posedge clk);
    n_fail++;
    print_verdict();
  end
  initial begin
    reset = 1'b1;
    {opValid, tablePointerLowLoad, tablePointerHighLoad} = 3'h0;
    {opCode, memReadData, tablePointerLoadData} = 21'h0;
    immediate = 8'h0f;
    dataAddr = 12'hf3c;
    bitSelect = 3'h3;
    repeat (4) @(negedge clk);
    reset = 1'b0;
    t_skip();
    t_table();
    t_arith();
    bitSelect = 3'h5;
    t_logic();
    print_verdict();
  end
endmodule
`default_nettype wire

//--- src/alu_skip_table_defines.vh
`ifndef ALU_SKIP_TABLE_DEFINES_VH
`define ALU_SKIP_TABLE_DEFINES_VH
// operation codes
`define OP_NOP 5'h00
`define OP_SKIP_ZERO_COPY 5'h01
`define OP_SKIP_BIT_ZERO 5'h02
`define OP_TABLE_READ_PAGED 5'h03
`define OP_TABLE_READ_LAST_PAGE 5'h04
`define OP_TABLE_READ_INC 5'h05
`define OP_TABLE_READ_INC_LAST_PAGE 5'h06
`define OP_XOR 5'h07
`define OP_XOR_IMMEDIATE 5'h08
`define OP_XOR_TO_MEMORY 5'h09
`define OP_WIDE_ADD_CARRY 5'h0a
`define OP_WIDE_ADD_CARRY_MEMORY 5'h0b
`define OP_WIDE_ADD 5'h0c
`define OP_WIDE_ADD_MEMORY 5'h0d
`define OP_WIDE_AND 5'h0e
`define OP_WIDE_AND_MEMORY 5'h0f
`define OP_WIDE_OR 5'h10
`define OP_WIDE_OR_MEMORY 5'h11
`define OP_WIDE_CLEAR 5'h12
`define OP_WIDE_CLEAR_BIT 5'h13
`define OP_WIDE_COMPLEMENT 5'h14
`define OP_WIDE_COMPLEMENT_TO_WORK 5'h15
`define OP_WIDE_DECIMAL_ADJUST 5'h16
`define OP_WIDE_DECREMENT 5'h17
`define OP_WIDE_DECREMENT_TO_WORK 5'h18
`define OP_WIDE_INCREMENT 5'h19
`define OP_WIDE_INCREMENT_TO_WORK 5'h1a
`define OP_WIDE_MOVE_TO_WORK 5'h1b
`define OP_WIDE_MOVE_TO_MEMORY 5'h1c
`define OP_WIDE_ROTATE_LEFT 5'h1d
// decimal adjust constants
`define BCD_DIGIT_MAX 4'h9
`define BCD_NIBBLE_ADJUST 4'h6
// reset values
`define WORK_RESET 8'h00
`define TABLE_PTR_RESET 8'h00
`define TABLE_LATCH_RESET 8'h00
`endif

//--- src/mcu_alu_skip_table.v
`include "alu_skip_table_defines.vh"
`default_nettype none
module mcu_alu_skip_table #(
  parameter DATA_ADDR_WIDTH = 12,
  parameter PROG_ADDR_WIDTH = 16,
  parameter PROG_WORD_WIDTH = 16
) (
  // clock and reset
  input wire clk,
  input wire reset,
  // instruction issue
  input wire opValid,
  input wire [4:0] opCode,
  input wire [2:0] bitSelect,
  input wire [7:0] immediate,
  input wire [DATA_ADDR_WIDTH-1:0] dataAddr,
  output wire opReady,
  // data memory
  output wire [DATA_ADDR_WIDTH-1:0] memAddr,
  input wire [7:0] memReadData,
  output reg memWrite,
  output reg [DATA_ADDR_WIDTH-1:0] memWriteAddr,
  output reg [7:0] memWriteData,
  // program memory
  output reg progRead,
  output reg [PROG_ADDR_WIDTH-1:0] progAddr,
  input wire [PROG_WORD_WIDTH-1:0] progData,
  // table pointer loads
  input wire tablePointerLowLoad,
  input wire tablePointerHighLoad,
  input wire [7:0] tablePointerLoadData,
  // architectural state
  output reg [7:0] workingRegister,
  output reg [7:0] tablePointerLow,
  output reg [7:0] tablePointerHigh,
  output reg [7:0] tableLatchHigh,
  output reg zeroFlag,
  output reg carryFlag,
  output reg nibbleCarryFlag,
  output reg signedExcessFlag,
  output reg signedCarryFlag,
  // sequencing
  output reg skipTaken,
  output reg dummyCycle
);
  localparam ST_RUN = 3'b001;
  localparam ST_TABLE = 3'b010;
  localparam ST_DUMMY = 3'b100;

  reg [2:0] state;
  reg [2:0] next_state;
  reg [DATA_ADDR_WIDTH-1:0] pendAddr;

  function isTableOp;
    input [4:0] code;
    begin
      isTableOp = (code == `OP_TABLE_READ_PAGED) ||
        (code == `OP_TABLE_READ_LAST_PAGE) ||
        (code == `OP_TABLE_READ_INC) ||
        (code == `OP_TABLE_READ_INC_LAST_PAGE);
    end
  endfunction

  function isLastPage;
    input [4:0] code;
    begin
      isLastPage = (code == `OP_TABLE_READ_LAST_PAGE) ||
        (code == `OP_TABLE_READ_INC_LAST_PAGE);
    end
  endfunction

  // full data address straight through for every section
  assign memAddr = dataAddr;
  assign opReady = (state == ST_RUN);

  wire issue = opValid && opReady;
  wire [7:0] operand = memReadData;
  wire [7:0] xorSource = (opCode == `OP_XOR_IMMEDIATE) ? immediate : operand;
  wire carryIn = (opCode == `OP_WIDE_ADD_CARRY ||
    opCode == `OP_WIDE_ADD_CARRY_MEMORY) ? carryFlag : 1'b0;
  wire [4:0] lowSum = {1'b0, workingRegister[3:0]} +
    {1'b0, operand[3:0]} + {4'h0, carryIn};
  wire [7:0] sevenSum = {1'b0, workingRegister[6:0]} +
    {1'b0, operand[6:0]} + {7'h00, carryIn};
  wire [8:0] fullSum = {1'b0, workingRegister} + {1'b0, operand} +
    {8'h00, carryIn};
  wire lowAdjust = (workingRegister[3:0] > `BCD_DIGIT_MAX) ||
    nibbleCarryFlag;
  wire highAdjust = (workingRegister[7:4] > `BCD_DIGIT_MAX) || carryFlag;
  wire [8:0] bcdSum = {1'b0, workingRegister} +
    {1'b0, highAdjust ? `BCD_NIBBLE_ADJUST : 4'h0,
    lowAdjust ? `BCD_NIBBLE_ADJUST : 4'h0};
  wire [7:0] bitMask = 8'h01 << bitSelect;

  reg [7:0] result;
  reg toWork;
  reg toMem;
  reg setZero;
  reg setAddFlags;
  reg setCarryOnly;
  reg takeSkip;

  always @* begin
    result = 8'h00;
    toWork = 1'b0;
    toMem = 1'b0;
    setZero = 1'b0;
    setAddFlags = 1'b0;
    setCarryOnly = 1'b0;
    takeSkip = 1'b0;
    case (opCode)
      `OP_SKIP_ZERO_COPY: begin
        result = operand;
        toWork = 1'b1;
        takeSkip = (operand == 8'h00);
      end
      `OP_SKIP_BIT_ZERO: begin
        takeSkip = ~operand[bitSelect];
      end
      `OP_XOR, `OP_XOR_IMMEDIATE: begin
        result = workingRegister ^ xorSource;
        toWork = 1'b1;
        setZero = 1'b1;
      end
      `OP_XOR_TO_MEMORY: begin
        result = workingRegister ^ operand;
        toMem = 1'b1;
        setZero = 1'b1;
      end
      `OP_WIDE_ADD_CARRY, `OP_WIDE_ADD: begin
        result = fullSum[7:0];
        toWork = 1'b1;
        setAddFlags = 1'b1;
      end
      `OP_WIDE_ADD_CARRY_MEMORY, `OP_WIDE_ADD_MEMORY: begin
        result = fullSum[7:0];
        toMem = 1'b1;
        setAddFlags = 1'b1;
      end
      `OP_WIDE_AND, `OP_WIDE_AND_MEMORY: begin
        result = workingRegister & operand;
        toWork = (opCode == `OP_WIDE_AND);
        toMem = (opCode == `OP_WIDE_AND_MEMORY);
        setZero = 1'b1;
      end
      `OP_WIDE_OR, `OP_WIDE_OR_MEMORY: begin
        result = workingRegister | operand;
        toWork = (opCode == `OP_WIDE_OR);
        toMem = (opCode == `OP_WIDE_OR_MEMORY);
        setZero = 1'b1;
      end
      `OP_WIDE_CLEAR: begin
        result = 8'h00;
        toMem = 1'b1;
      end
      `OP_WIDE_CLEAR_BIT: begin
        result = operand & ~bitMask;
        toMem = 1'b1;
      end
      `OP_WIDE_COMPLEMENT, `OP_WIDE_COMPLEMENT_TO_WORK: begin
        result = ~operand;
        toWork = (opCode == `OP_WIDE_COMPLEMENT_TO_WORK);
        toMem = (opCode == `OP_WIDE_COMPLEMENT);
        setZero = 1'b1;
      end
      `OP_WIDE_DECIMAL_ADJUST: begin
        result = bcdSum[7:0];
        toMem = 1'b1;
        setCarryOnly = 1'b1;
      end
      `OP_WIDE_DECREMENT, `OP_WIDE_DECREMENT_TO_WORK: begin
        result = operand - 8'h01;
        toWork = (opCode == `OP_WIDE_DECREMENT_TO_WORK);
        toMem = (opCode == `OP_WIDE_DECREMENT);
        setZero = 1'b1;
      end
      `OP_WIDE_INCREMENT, `OP_WIDE_INCREMENT_TO_WORK: begin
        result = operand + 8'h01;
        toWork = (opCode == `OP_WIDE_INCREMENT_TO_WORK);
        toMem = (opCode == `OP_WIDE_INCREMENT);
        setZero = 1'b1;
      end
      `OP_WIDE_MOVE_TO_WORK: begin
        result = operand;
        toWork = 1'b1;
      end
      `OP_WIDE_MOVE_TO_MEMORY: begin
        result = workingRegister;
        toMem = 1'b1;
      end
      `OP_WIDE_ROTATE_LEFT: begin
        result = {operand[6:0], operand[7]};
        toMem = 1'b1;
      end
      default: begin
        result = 8'h00;
      end
    endcase
  end

  always @* begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (issue && isTableOp(opCode))
          next_state = ST_TABLE;
        else if (issue && takeSkip)
          next_state = ST_DUMMY;
      end
      ST_TABLE: next_state = ST_RUN;
      ST_DUMMY: next_state = ST_RUN;
      default: next_state = ST_RUN;
    endcase
  end

  wire incFirst = (opCode == `OP_TABLE_READ_INC) ||
    (opCode == `OP_TABLE_READ_INC_LAST_PAGE);
  wire [7:0] pointerUsed = incFirst ? tablePointerLow + 8'h01 :
    tablePointerLow;
  wire [7:0] pageUsed = isLastPage(opCode) ?
    {8{1'b1}} : tablePointerHigh;
  // upper address bits beyond 16 are all ones
  wire [PROG_ADDR_WIDTH+15:0] tableWide = {{PROG_ADDR_WIDTH{1'b1}},
    pageUsed, pointerUsed};

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= ST_RUN;
      pendAddr <= {DATA_ADDR_WIDTH{1'b0}};
      workingRegister <= `WORK_RESET;
      tablePointerLow <= `TABLE_PTR_RESET;
      tablePointerHigh <= `TABLE_PTR_RESET;
      tableLatchHigh <= `TABLE_LATCH_RESET;
      zeroFlag <= 1'b0;
      carryFlag <= 1'b0;
      nibbleCarryFlag <= 1'b0;
      signedExcessFlag <= 1'b0;
      signedCarryFlag <= 1'b0;
      memWrite <= 1'b0;
      memWriteAddr <= {DATA_ADDR_WIDTH{1'b0}};
      memWriteData <= 8'h00;
      progRead <= 1'b0;
      progAddr <= {PROG_ADDR_WIDTH{1'b0}};
      skipTaken <= 1'b0;
      dummyCycle <= 1'b0;
    end else begin
      state <= next_state;
      memWrite <= 1'b0;
      progRead <= 1'b0;
      skipTaken <= 1'b0;
      dummyCycle <= (next_state == ST_DUMMY);
      if (tablePointerLowLoad && opReady)
        tablePointerLow <= tablePointerLoadData;
      if (tablePointerHighLoad && opReady)
        tablePointerHigh <= tablePointerLoadData;
      if (issue && isTableOp(opCode)) begin
        if (incFirst)
          tablePointerLow <= pointerUsed;
        progRead <= 1'b1;
        progAddr <= tableWide[PROG_ADDR_WIDTH-1:0];
        pendAddr <= dataAddr;
      end else if (issue) begin
        skipTaken <= takeSkip;
        if (toWork)
          workingRegister <= result;
        if (toMem) begin
          memWrite <= 1'b1;
          memWriteAddr <= dataAddr;
          memWriteData <= result;
        end
        if (setZero || setAddFlags)
          zeroFlag <= (result == 8'h00);
        if (setAddFlags) begin
          nibbleCarryFlag <= lowSum[4];
          carryFlag <= fullSum[8];
          signedExcessFlag <= sevenSum[7] ^ fullSum[8];
          signedCarryFlag <= fullSum[7] ^ sevenSum[7] ^ fullSum[8];
        end
        if (setCarryOnly)
          carryFlag <= carryFlag | bcdSum[8];
      end
      if (state == ST_TABLE) begin
        memWrite <= 1'b1;
        memWriteAddr <= pendAddr;
        memWriteData <= progData[7:0];
        tableLatchHigh <= progData[15:8];
      end
    end
  end
endmodule
`default_nettype wire
